// ==== bench/cpu_register_file_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
	$display("[ERR] %s expected %h seen %h", what, exp, got); bad_count++; end end

module cpu_register_file_tb;
	import crf_pkg::*;

	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	logic        clock;
	logic        resetn;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	crf_wr_t     core_wr;
	crf_alu_t    alu_upd;
	crf_step_t   instr_step;
	crf_sel_t    rd_sel;
	logic [31:0] rd_data;
	logic [19:0] next_instr_addr;
	logic [19:0] vector_table_base;
	logic [10:0] cpu_state_flags;
	int          bad_count;
	int          comparisons;
	logic [31:0] junk;

	localparam logic [31:0] PAT = 32'ha5c39e71;
	localparam logic [7:0] OFS [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
		8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
	localparam logic [31:0] MSK [13] = '{32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff,
		32'hffff, 32'hffff, 32'hfffff, 32'hfffff, 32'hffff, 32'hffff, 32'hffff, 32'h7ff};

	crf_core_regs #(.ADR_W(8)) u_crf_core_regs (
		.clock             (clock),
		.resetn            (resetn),
		.wb_cyc_i          (wb_cyc_i),
		.wb_stb_i          (wb_stb_i),
		.wb_we_i           (wb_we_i),
		.wb_adr_i          (wb_adr_i),
		.wb_sel_i          (wb_sel_i),
		.wb_dat_i          (wb_dat_i),
		.wb_dat_o          (wb_dat_o),
		.wb_ack_o          (wb_ack_o),
		.core_wr           (core_wr),
		.alu_upd           (alu_upd),
		.instr_step        (instr_step),
		.rd_sel            (rd_sel),
		.rd_data           (rd_data),
		.next_instr_addr   (next_instr_addr),
		.vector_table_base (vector_table_base),
		.cpu_state_flags   (cpu_state_flags)
	);

	always #20 clock = ~clock;

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Slave answers after one cycle; the bound only guards against a hang
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel, output logic [31:0] rdat);
		int n;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_xfer(1'b1, adr, dat, 4'hf, junk);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
		logic [31:0] got;
		wb_xfer(1'b0, adr, 32'h0, 4'hf, got);
		`CHK(what, exp, got)
	endtask

	task automatic core_put(input crf_sel_t s, input logic [31:0] d);
		@(posedge clock);
		core_wr <= '{en: 1'b1, sel: s, data: d};
		@(posedge clock);
		core_wr.en <= 1'b0;
	endtask

	// Read port is registered: settle select, then one edge to capture
	task automatic core_chk(input crf_sel_t s, input logic [31:0] exp, input string what);
		@(posedge clock);
		rd_sel <= s;
		repeat (2) @(posedge clock);
		`CHK(what, exp, rd_data)
	endtask

	task automatic alu_chk(input crf_size_t sz, input logic [31:0] res, input logic c,
		input logic o, input logic z, input logic s);
		@(posedge clock);
		alu_upd <= '{en: 1'b1, size: sz, result: res, carry: c, overflow: o};
		@(posedge clock);
		alu_upd.en <= 1'b0;
		@(posedge clock);
		`CHK("alu flags", {o, s, z, c}, {cpu_state_flags[FLAG_OVF], cpu_state_flags[FLAG_SIGN],
			cpu_state_flags[FLAG_ZERO], cpu_state_flags[FLAG_CARRY]})
	endtask

	task automatic step(input logic [2:0] l);
		@(posedge clock);
		instr_step <= '{en: 1'b1, len: l};
		@(posedge clock);
		instr_step.en <= 1'b0;
		@(posedge clock);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		core_wr = '0;
		alu_upd = '0;
		instr_step = '0;
		rd_sel = SEL_DATA_A;
		bad_count = 0;
		comparisons = 0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("pc reset", 20'h00000, next_instr_addr)
		for (int i = 0; i < 13; i++) rd_chk(OFS[i], 32'h0, "reset value");
		// Flags go last: the pattern sets the bank bit
		for (int i = 0; i < 13; i++) begin
			wr(OFS[i], PAT);
			rd_chk(OFS[i], PAT & MSK[i], "width");
		end
		`CHK("vector out", 20'h39e71, vector_table_base)
		wr(OFS[12], 32'h10);
		// The write lands on the ack edge; look one edge later
		@(posedge clock);
		`CHK("bank bit", 11'h010, cpu_state_flags)
		`CHK("debug bit", 1'b0, cpu_state_flags[FLAG_DEBUG])
		rd_chk(OFS[0], 32'h0, "bank1 data_a");
		core_put(SEL_DATA_A, 32'h1111);
		rd_chk(OFS[0], 32'h1111, "bank1 write");
		wr(OFS[12], 32'h0);
		rd_chk(OFS[0], 32'h9e71, "bank0 kept");
		core_chk(SEL_CA_PAIR, 32'h9e719e71, "ca before");
		core_put(SEL_CA_PAIR, 32'h12345678);
		rd_chk(OFS[2], 32'h1234, "ca upper");
		rd_chk(OFS[0], 32'h5678, "ca lower");
		core_put(SEL_DB_PAIR, 32'h9abcdef0);
		core_chk(SEL_DB_PAIR, 32'h9abcdef0, "db pair");
		core_put(SEL_PTR_PAIR, 32'h01020304);
		rd_chk(OFS[5], 32'h0102, "ptr upper");
		core_chk(SEL_PTR_FIRST, 32'h0304, "ptr lower");
		core_put(SEL_A_UPPER, 32'h00ab);
		core_chk(SEL_DATA_A, 32'hab78, "a upper");
		core_chk(SEL_A_LOWER, 32'h0078, "a lower");
		core_put(SEL_B_LOWER, 32'h00cd);
		core_chk(SEL_DATA_B, 32'hdecd, "b lower");
		core_chk(SEL_B_UPPER, 32'h00de, "b upper");
		core_put(SEL_B_UPPER, 32'h0012);
		core_chk(SEL_DATA_B, 32'h12cd, "b upper wr");
		wr(OFS[9], 32'h1234);
		wr(OFS[10], 32'h5678);
		wr(OFS[12], 32'h80);
		rd_chk(8'h34, 32'h1234, "user stack");
		core_chk(SEL_ACT_STK, 32'h1234, "act stack");
		core_put(SEL_ACT_STK, 32'h4321);
		core_chk(SEL_USER_STK, 32'h4321, "act stack wr");
		wr(OFS[12], 32'h0);
		rd_chk(8'h34, 32'h5678, "irq stack");
		wb_xfer(1'b1, OFS[11], 32'h0000ab00, 4'h2, junk);
		rd_chk(OFS[11], 32'hab71, "byte lane");
		alu_chk(SZ_WORD, 32'h00000000, 1'b1, 1'b0, 1'b1, 1'b0);
		alu_chk(SZ_WORD, 32'h00008000, 1'b0, 1'b1, 1'b0, 1'b1);
		alu_chk(SZ_BYTE, 32'h00000100, 1'b1, 1'b0, 1'b1, 1'b0);
		alu_chk(SZ_BYTE, 32'h00000080, 1'b0, 1'b0, 1'b0, 1'b1);
		alu_chk(SZ_LONG, 32'h80000000, 1'b1, 1'b1, 1'b0, 1'b1);
		wr(OFS[8], 32'h000ffffe);
		step(3'd3);
		`CHK("pc wrap", 20'h00001, next_instr_addr)
		step(3'd7);
		`CHK("pc step", 20'h00008, next_instr_addr)
		// Unmapped and unaligned places answer with zero
		rd_chk(8'h38, 32'h0, "unmapped");
		wr(8'h3c, 32'hffffffff);
		rd_chk(8'h3c, 32'h0, "unmapped wr");
		rd_chk(8'h02, 32'h0, "unaligned");
		tally_and_finish();
	end
endmodule

`default_nettype wire

// ==== design/crf_core_regs.sv ====
// Summary of operation
// - Thirteen architectural registers exist, banked and non-banked counted together.
// - Data, address and frame base registers form a bank; two copies exist.
// - First two data registers work as 16-bit words or separate byte halves.
// - Third with first, and fourth with second, form 32-bit data operands.
// - Address registers are 16-bit bases for indirect addressing and plain operands.
// - Address pointers pair into one 32-bit register, second pointer upper.
// - Frame base register is 16 bits, base for frame-relative addressing.
// - Vector table base is 20 bits, holding the vector table start.
// - Program counter is 20 bits and holds the next instruction address.
// - User and interrupt stack pointers are 16 bits; one active at once.
// - Stack-select flag bit chooses which stack pointer is active.
// - Static base register is 16 bits, base for static-relative addressing.
// - Flag register is 11 bits holding condition, bank and stack bits.
// - Carry bit captures carry, borrow or shift-out of every unit operation.
// - Zero bit is one for a zero result, else cleared.
// - Sign bit is one for a negative result, else cleared.
// - Bank flag zero selects first bank, one selects second bank.
// - Overflow bit is one when an operation overflows, else cleared.
`timescale 1ns/1ps
`default_nettype none

module crf_core_regs #(
	parameter int          ADR_W    = 8,
	parameter logic [19:0] PC_RESET = crf_pkg::RST_ADDR
) (
	input  wire logic               clock,
	input  wire logic               resetn,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	input  wire crf_pkg::crf_wr_t   core_wr,
	input  wire crf_pkg::crf_alu_t  alu_upd,
	input  wire crf_pkg::crf_step_t instr_step,
	input  wire crf_pkg::crf_sel_t  rd_sel,
	output logic      [31:0]        rd_data,
	output logic      [19:0]        next_instr_addr,
	output logic      [19:0]        vector_table_base,
	output logic      [10:0]        cpu_state_flags
);
	import crf_pkg::*;

	if (ADR_W < 6 || ADR_W > 16) begin : g_bad_adr
		$error("ADR_W must lie between 6 and 16");
	end

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	crf_bank_t [1:0] bank;
	logic [15:0]     user_stack_ptr;
	logic [15:0]     irq_stack_ptr;
	logic [15:0]     static_base_ptr;
	crf_state_t      cur;
	crf_state_t      next_st;

	assign cur = '{bank: bank, vector: vector_table_base, instr: next_instr_addr,
		user_stk: user_stack_ptr, irq_stk: irq_stack_ptr,
		static_base: static_base_ptr, flags: cpu_state_flags};

	// ----------------------------------------
	// Access functions
	// ----------------------------------------
	// Banked selects always resolve through the live bank flag
	function automatic crf_state_t st_write(crf_state_t s, crf_sel_t sel, logic [31:0] d);
		crf_state_t r;
		logic       b;
		r = s;
		b = s.flags[FLAG_BANK];
		unique case (sel)
			SEL_DATA_A:     r.bank[b].data_a = d[15:0];
			SEL_DATA_B:     r.bank[b].data_b = d[15:0];
			SEL_DATA_C:     r.bank[b].data_c = d[15:0];
			SEL_DATA_D:     r.bank[b].data_d = d[15:0];
			SEL_A_UPPER:    r.bank[b].data_a[15:8] = d[7:0];
			SEL_A_LOWER:    r.bank[b].data_a[7:0] = d[7:0];
			SEL_B_UPPER:    r.bank[b].data_b[15:8] = d[7:0];
			SEL_B_LOWER:    r.bank[b].data_b[7:0] = d[7:0];
			SEL_CA_PAIR: begin
				r.bank[b].data_c = d[31:16];
				r.bank[b].data_a = d[15:0];
			end
			SEL_DB_PAIR: begin
				r.bank[b].data_d = d[31:16];
				r.bank[b].data_b = d[15:0];
			end
			SEL_PTR_FIRST:  r.bank[b].ptr_first = d[15:0];
			SEL_PTR_SECOND: r.bank[b].ptr_second = d[15:0];
			SEL_PTR_PAIR: begin
				r.bank[b].ptr_second = d[31:16];
				r.bank[b].ptr_first  = d[15:0];
			end
			SEL_FRAME:      r.bank[b].frame = d[15:0];
			SEL_VECTOR:     r.vector = d[19:0];
			SEL_INSTR:      r.instr = d[19:0];
			SEL_USER_STK:   r.user_stk = d[15:0];
			SEL_IRQ_STK:    r.irq_stk = d[15:0];
			SEL_ACT_STK: begin
				if (s.flags[FLAG_STACK]) begin
					r.user_stk = d[15:0];
				end else begin
					r.irq_stk = d[15:0];
				end
			end
			SEL_STATIC:     r.static_base = d[15:0];
			SEL_FLAGS:      r.flags = d[10:0];
			default:        r = s;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] st_read(crf_state_t s, crf_sel_t sel);
		crf_bank_t k;
		k = s.bank[s.flags[FLAG_BANK]];
		unique case (sel)
			SEL_DATA_A:     return {16'h0000, k.data_a};
			SEL_DATA_B:     return {16'h0000, k.data_b};
			SEL_DATA_C:     return {16'h0000, k.data_c};
			SEL_DATA_D:     return {16'h0000, k.data_d};
			SEL_A_UPPER:    return {24'h000000, k.data_a[15:8]};
			SEL_A_LOWER:    return {24'h000000, k.data_a[7:0]};
			SEL_B_UPPER:    return {24'h000000, k.data_b[15:8]};
			SEL_B_LOWER:    return {24'h000000, k.data_b[7:0]};
			SEL_CA_PAIR:    return {k.data_c, k.data_a};
			SEL_DB_PAIR:    return {k.data_d, k.data_b};
			SEL_PTR_FIRST:  return {16'h0000, k.ptr_first};
			SEL_PTR_SECOND: return {16'h0000, k.ptr_second};
			SEL_PTR_PAIR:   return {k.ptr_second, k.ptr_first};
			SEL_FRAME:      return {16'h0000, k.frame};
			SEL_VECTOR:     return {12'h000, s.vector};
			SEL_INSTR:      return {12'h000, s.instr};
			SEL_USER_STK:   return {16'h0000, s.user_stk};
			SEL_IRQ_STK:    return {16'h0000, s.irq_stk};
			SEL_ACT_STK:    return {16'h0000,
				s.flags[FLAG_STACK] ? s.user_stk : s.irq_stk};
			SEL_STATIC:     return {16'h0000, s.static_base};
			SEL_FLAGS:      return {21'h000000, s.flags};
			default:        return 32'h0000_0000;
		endcase
	endfunction

	// Only word-aligned offsets of the map decode; anything else is unmapped
	function automatic crf_dec_t bus_decode(logic [ADR_W-1:0] a);
		crf_dec_t   r;
		logic [7:0] a8;
		r = '{ok: 1'b1, sel: SEL_DATA_A};
		// Narrow buses zero-extend; wide ones are already range-checked below
		a8 = 8'(a);
		if (a[1:0] != 2'b00 || a > ADR_W'(OFS_ACTIVE_STACK)) begin
			r.ok = 1'b0;
		end else begin
			unique case (a8)
				OFS_GP_DATA_A:       r.sel = SEL_DATA_A;
				OFS_GP_DATA_B:       r.sel = SEL_DATA_B;
				OFS_GP_DATA_C:       r.sel = SEL_DATA_C;
				OFS_GP_DATA_D:       r.sel = SEL_DATA_D;
				OFS_ADDR_PTR_FIRST:  r.sel = SEL_PTR_FIRST;
				OFS_ADDR_PTR_SECOND: r.sel = SEL_PTR_SECOND;
				OFS_FRAME_BASE_PTR:  r.sel = SEL_FRAME;
				OFS_VECTOR_TABLE:    r.sel = SEL_VECTOR;
				OFS_NEXT_INSTR:      r.sel = SEL_INSTR;
				OFS_USER_STACK:      r.sel = SEL_USER_STK;
				OFS_IRQ_STACK:       r.sel = SEL_IRQ_STK;
				OFS_STATIC_BASE:     r.sel = SEL_STATIC;
				OFS_STATE_FLAGS:     r.sel = SEL_FLAGS;
				OFS_ACTIVE_STACK:    r.sel = SEL_ACT_STK;
				default:             r.ok = 1'b0;
			endcase
		end
		return r;
	endfunction

	// ----------------------------------------
	// Bus slave signals
	// ----------------------------------------
	crf_dec_t    dec;
	logic        bus_req;
	logic        bus_wr;
	logic [31:0] be_mask;
	logic [31:0] bus_data;
	logic        alu_zero;
	logic        alu_sign;

	assign dec      = bus_decode(wb_adr_i);
	assign bus_req  = wb_cyc_i && wb_stb_i;
	// Write lands on the edge where the master sees ack
	assign bus_wr   = bus_req && wb_we_i && wb_ack_o && dec.ok;
	assign be_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign bus_data = (st_read(cur, dec.sel) & ~be_mask) | (wb_dat_i & be_mask);

	crf_flag_calc u_flag_calc (
		.size   (alu_upd.size),
		.result (alu_upd.result),
		.zero   (alu_zero),
		.sign   (alu_sign)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Order sets priority: step, unit flags, core write, then bus write last
	always_comb begin
		next_st = cur;
		if (instr_step.en) begin
			next_st.instr = cur.instr + {17'h00000, instr_step.len};
		end
		if (alu_upd.en) begin
			next_st.flags[FLAG_CARRY] = alu_upd.carry;
			next_st.flags[FLAG_ZERO]  = alu_zero;
			next_st.flags[FLAG_SIGN]  = alu_sign;
			next_st.flags[FLAG_OVF]   = alu_upd.overflow;
		end
		if (core_wr.en) begin
			next_st = st_write(next_st, core_wr.sel, core_wr.data);
		end
		if (bus_wr) begin
			next_st = st_write(next_st, dec.sel, bus_data);
		end
	end

	// ----------------------------------------
	// Register bank copies
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bank <= {2{RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD}};
		end else begin
			bank <= next_st.bank;
		end
	end

	// ----------------------------------------
	// Non-banked registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vector_table_base <= RST_ADDR;
		end else begin
			vector_table_base <= next_st.vector;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			next_instr_addr <= PC_RESET;
		end else begin
			next_instr_addr <= next_st.instr;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			user_stack_ptr <= RST_WORD;
			irq_stack_ptr  <= RST_WORD;
		end else begin
			user_stack_ptr <= next_st.user_stk;
			irq_stack_ptr  <= next_st.irq_stk;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			static_base_ptr <= RST_WORD;
		end else begin
			static_base_ptr <= next_st.static_base;
		end
	end

	// Debug bit is stored as written; keeping it clear is up to software
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cpu_state_flags <= RST_FLAGS;
		end else begin
			cpu_state_flags <= next_st.flags;
		end
	end

	// ----------------------------------------
	// Bus answer and core read port
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= dec.ok ? st_read(cur, dec.sel) : 32'h0000_0000;
			end
		end
	end

	// Shows the state before this edge's writes; no write-through bypass
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= st_read(cur, rd_sel);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic core_only;
	logic alu_only;

	assign core_only = core_wr.en && !bus_wr;
	assign alu_only  = alu_upd.en && !core_wr.en && !bus_wr;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_bank_iso;
		core_only && core_wr.sel == SEL_DATA_A && !cpu_state_flags[FLAG_BANK]
		|=> bank[0].data_a == $past(core_wr.data[15:0])
			&& $stable(bank[1].data_a);
	endproperty
	a_bank_iso: assert property (p_bank_iso) else $error("bank write leaked");

	property p_byte_upper;
		core_only && core_wr.sel == SEL_B_UPPER
		|=> bank[$past(cpu_state_flags[FLAG_BANK])].data_b[15:8] == $past(core_wr.data[7:0])
			&& bank[$past(cpu_state_flags[FLAG_BANK])].data_b[7:0]
			== $past(bank[cpu_state_flags[FLAG_BANK]].data_b[7:0]);
	endproperty
	a_byte_upper: assert property (p_byte_upper) else $error("byte half write wrong");

	property p_pair_read;
		core_only && core_wr.sel == SEL_CA_PAIR && rd_sel == SEL_CA_PAIR
		##1 rd_sel == SEL_CA_PAIR && !core_wr.en && !bus_wr
		|=> rd_data == $past(core_wr.data, 2);
	endproperty
	a_pair_read: assert property (p_pair_read) else $error("data pair mismatch");

	property p_ptr_pair;
		core_only && core_wr.sel == SEL_PTR_PAIR && !cpu_state_flags[FLAG_BANK]
		|=> bank[0].ptr_second == $past(core_wr.data[31:16])
			&& bank[0].ptr_first == $past(core_wr.data[15:0]);
	endproperty
	a_ptr_pair: assert property (p_ptr_pair) else $error("pointer pair wrong");

	property p_act_stack;
		core_only && core_wr.sel == SEL_ACT_STK && cpu_state_flags[FLAG_STACK]
		|=> user_stack_ptr == $past(core_wr.data[15:0]) && $stable(irq_stack_ptr);
	endproperty
	a_act_stack: assert property (p_act_stack) else $error("wrong stack updated");

	property p_carry;
		alu_only |=> cpu_state_flags[FLAG_CARRY] == $past(alu_upd.carry);
	endproperty
	a_carry: assert property (p_carry) else $error("carry not captured");

	property p_zero;
		alu_only && alu_upd.size == SZ_BYTE
		|=> cpu_state_flags[FLAG_ZERO] == ($past(alu_upd.result[7:0]) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_sign;
		alu_only && alu_upd.size == SZ_LONG
		|=> cpu_state_flags[FLAG_SIGN] == $past(alu_upd.result[31]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");

	property p_ovf;
		alu_only |=> cpu_state_flags[FLAG_OVF] == $past(alu_upd.overflow);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

	property p_step;
		instr_step.en && !core_wr.en && !bus_wr
		|=> next_instr_addr == $past(next_instr_addr) + 20'($past(instr_step.len));
	endproperty
	a_step: assert property (p_step) else $error("instruction address step wrong");

	property p_ack;
		bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack timing wrong");

	c_bank_swap: cover property (core_wr.en && core_wr.sel == SEL_FLAGS
		&& core_wr.data[FLAG_BANK] != cpu_state_flags[FLAG_BANK]);
	c_bus_write: cover property (bus_wr);
	c_pair_wr: cover property (core_only && core_wr.sel == SEL_DB_PAIR);
	c_zero_hit: cover property (alu_only && alu_zero);

endmodule

`default_nettype wire

// ==== design/crf_flag_calc.sv ====
`timescale 1ns/1ps
`default_nettype none

module crf_flag_calc (
	input  wire crf_pkg::crf_size_t size,
	input  wire logic [31:0]        result,
	output logic                    zero,
	output logic                    sign
);
	import crf_pkg::*;

	// ----------------------------------------
	// Zero and sign at the operand width
	// ----------------------------------------
	always_comb begin
		unique case (size)
			SZ_BYTE: begin
				zero = (result[7:0] == 8'h00);
				sign = result[7];
			end
			SZ_WORD: begin
				zero = (result[15:0] == 16'h0000);
				sign = result[15];
			end
			SZ_LONG: begin
				zero = (result == 32'h0000_0000);
				sign = result[31];
			end
			default: begin
				// Unused size code reports a clean non-zero positive result
				zero = 1'b0;
				sign = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

// ==== design/crf_pkg.sv ====
`default_nettype none

package crf_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int WORD_W = 16;
	localparam int ADDR_W = 20;
	localparam int FLAG_W = 11;

	// ----------------------------------------
	// Bus offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_GP_DATA_A       = 8'h00;
	localparam logic [7:0] OFS_GP_DATA_B       = 8'h04;
	localparam logic [7:0] OFS_GP_DATA_C       = 8'h08;
	localparam logic [7:0] OFS_GP_DATA_D       = 8'h0c;
	localparam logic [7:0] OFS_ADDR_PTR_FIRST  = 8'h10;
	localparam logic [7:0] OFS_ADDR_PTR_SECOND = 8'h14;
	localparam logic [7:0] OFS_FRAME_BASE_PTR  = 8'h18;
	localparam logic [7:0] OFS_VECTOR_TABLE    = 8'h1c;
	localparam logic [7:0] OFS_NEXT_INSTR      = 8'h20;
	localparam logic [7:0] OFS_USER_STACK      = 8'h24;
	localparam logic [7:0] OFS_IRQ_STACK       = 8'h28;
	localparam logic [7:0] OFS_STATIC_BASE     = 8'h2c;
	localparam logic [7:0] OFS_STATE_FLAGS     = 8'h30;
	localparam logic [7:0] OFS_ACTIVE_STACK    = 8'h34;

	// ----------------------------------------
	// Flag bit positions
	// ----------------------------------------
	localparam int FLAG_CARRY  = 0;
	localparam int FLAG_DEBUG  = 1;
	localparam int FLAG_ZERO   = 2;
	localparam int FLAG_SIGN   = 3;
	localparam int FLAG_BANK   = 4;
	localparam int FLAG_OVF    = 5;
	localparam int FLAG_IRQEN  = 6;
	localparam int FLAG_STACK  = 7;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [19:0] RST_ADDR  = 20'h00000;
	localparam logic [10:0] RST_FLAGS = 11'h000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		SEL_DATA_A, SEL_DATA_B, SEL_DATA_C, SEL_DATA_D,
		SEL_A_UPPER, SEL_A_LOWER, SEL_B_UPPER, SEL_B_LOWER,
		SEL_CA_PAIR, SEL_DB_PAIR,
		SEL_PTR_FIRST, SEL_PTR_SECOND, SEL_PTR_PAIR, SEL_FRAME,
		SEL_VECTOR, SEL_INSTR, SEL_USER_STK, SEL_IRQ_STK,
		SEL_ACT_STK, SEL_STATIC, SEL_FLAGS
	} crf_sel_t;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_t;

	typedef struct packed {
		logic        en;
		crf_sel_t    sel;
		logic [31:0] data;
	} crf_wr_t;

	typedef struct packed {
		logic        en;
		crf_size_t   size;
		logic [31:0] result;
		logic        carry;
		logic        overflow;
	} crf_alu_t;

	typedef struct packed {
		logic       en;
		logic [2:0] len;
	} crf_step_t;

	typedef struct packed {
		logic     ok;
		crf_sel_t sel;
	} crf_dec_t;

	typedef struct packed {
		logic [15:0] data_a;
		logic [15:0] data_b;
		logic [15:0] data_c;
		logic [15:0] data_d;
		logic [15:0] ptr_first;
		logic [15:0] ptr_second;
		logic [15:0] frame;
	} crf_bank_t;

	typedef struct packed {
		crf_bank_t [1:0] bank;
		logic [19:0]     vector;
		logic [19:0]     instr;
		logic [15:0]     user_stk;
		logic [15:0]     irq_stk;
		logic [15:0]     static_base;
		logic [10:0]     flags;
	} crf_state_t;

endpackage

`default_nettype wire
